// *** hdl/aerue_defs.svh ***
// Constants for the uncorrectable error reporting register bank
// Notes on behaviour
// - Capability word upper 12 bits read zero: last entry of capability chain.
// - Capability word bits 19:16 read version 1h; whole word read-only.
// - Status bit clears only when software writes one to it or a reset is applied.
// - Unsupported request received sets status bit 20.
// - End-to-end CRC mismatch sets status bit 19.
// - Malformed packet received sets status bit 18.
// - Partner exceeding advertised credits sets status bit 17.
// - Completion matching no outstanding request sets status bit 16.
// - Bridge returning completer-abort sets status bit 15.
// - Request unanswered within timeout sets status bit 14.
// - Flow control protocol violation sets status bit 13.
// - Poisoned packet received sets status bit 12.
// - Data link layer protocol error sets status bit 4.
// - Access control violation unsupported; status bit 21 reads zero.
// - Surprise link-down unsupported; status bit 5 reads zero.
// - Status bits 31:22, 11:6 and 3:0 read zero.
// - Masked error neither sets status nor sends error message.
// - Masked error neither loads header log nor updates first-error pointer.
// - Link reset, global reset or power-on reset clear status bits.
// - Implemented mask bits writable, reset to zero, same positions as status.
// - Mask bits 21 and 5 unimplemented and read zero.
`ifndef AERUE_DEFS_SVH
`define AERUE_DEFS_SVH

// Dword indexes (byte offset / 4) of the configuration space
`define AERUE_IDX_CAP      10'h040
`define AERUE_IDX_STATUS   10'h041
`define AERUE_IDX_MASK     10'h042

// Printed byte offsets
`define AERUE_OFS_NEXT_VER 12'h102
`define AERUE_OFS_STATUS   12'h104
`define AERUE_OFS_MASK     12'h108

// Capability word fields
`define AERUE_NEXT_PTR     12'h000
`define AERUE_CAP_VERSION  4'h1
`define AERUE_NEXT_VER_RST 16'h0001

// Bit positions
`define AERUE_BIT_UR       20
`define AERUE_BIT_ECRC     19
`define AERUE_BIT_MAL      18
`define AERUE_BIT_OVF      17
`define AERUE_BIT_UNXP     16
`define AERUE_BIT_CA       15
`define AERUE_BIT_CTO      14
`define AERUE_BIT_FC       13
`define AERUE_BIT_PSN      12
`define AERUE_BIT_DLL      4

// Implemented bits (status and mask share the layout)
`define AERUE_IMPL_BITS    32'h001ff010
`define AERUE_STATUS_RST   32'h00000000
`define AERUE_MASK_RST     32'h00000000

`endif

// *** hdl/aerue_pkg.sv ***
// Types for the uncorrectable error reporting register bank
package aerue_pkg;
  typedef logic [31:0] aerue_word_t;
  typedef logic [3:0]  aerue_be_t;
  typedef logic [4:0]  aerue_bitidx_t;
  typedef enum logic [1:0] {
    AERUE_RST_IDLE   = 2'b00,
    AERUE_RST_ACTIVE = 2'b01
  } aerue_rst_state_t;
endpackage

// *** hdl/aerue_regs.sv ***
// Uncorrectable error status, mask and capability version registers
`timescale 1ns/100ps
`include "aerue_defs.svh"

module aerue_regs
  import aerue_pkg::*;
(
  // Clock and power-on reset
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  // Reset pins from outside the clock domain
  input  wire logic          link_reset_n,
  input  wire logic          global_reset_n,
  // Configuration access port
  input  wire logic          cfg_wr,
  input  wire logic          cfg_rd,
  input  wire logic [11:0]   cfg_addr,
  input  wire logic [3:0]    cfg_be,
  input  wire logic [31:0]   cfg_wdata,
  output logic      [31:0]   cfg_rdata,
  output logic               cfg_rd_valid,
  // Error detection pulses from the link logic
  input  wire logic          unsupported_request_flag,
  input  wire logic          end_to_end_crc_flag,
  input  wire logic          malformed_packet_flag,
  input  wire logic          receiver_overflow_flag,
  input  wire logic          unmatched_completion_flag,
  input  wire logic          completer_abort_flag,
  input  wire logic          completion_timeout_flag,
  input  wire logic          flow_control_protocol_flag,
  input  wire logic          poisoned_packet_flag,
  input  wire logic          data_link_protocol_flag,
  input  wire logic          access_control_violation_flag,
  input  wire logic          surprise_link_down_flag,
  // Reporting outputs
  output logic      [31:0]   err_msg_req,
  output logic               hdr_log_load,
  output logic               first_err_load,
  output logic      [4:0]    first_err_index,
  output logic      [31:0]   uncor_status,
  output logic      [31:0]   uncor_mask
);

  ////////////////////////////////////////////////////////////////////////////
  // External reset pins: three-stage synchronisers

  logic [2:0]       link_rst_sync;
  logic [2:0]       glob_rst_sync;
  aerue_rst_state_t ext_rst_state;
  logic             ext_rst_active;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_rst_sync <= 3'h0;
      glob_rst_sync <= 3'h0;
    end else begin
      link_rst_sync <= {link_rst_sync[1:0], link_reset_n};
      glob_rst_sync <= {glob_rst_sync[1:0], global_reset_n};
    end
  end

  // A level counts only once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_rst_state <= AERUE_RST_ACTIVE;
    end else begin
      unique case (ext_rst_state)
        AERUE_RST_IDLE: begin
          if ((link_rst_sync[2:1] == 2'b00) || (glob_rst_sync[2:1] == 2'b00)) begin
            ext_rst_state <= AERUE_RST_ACTIVE;
          end
        end
        AERUE_RST_ACTIVE: begin
          if ((link_rst_sync[2:1] == 2'b11) && (glob_rst_sync[2:1] == 2'b11)) begin
            ext_rst_state <= AERUE_RST_IDLE;
          end
        end
        default: ext_rst_state <= AERUE_RST_ACTIVE;
      endcase
    end
  end

  assign ext_rst_active = (ext_rst_state == AERUE_RST_ACTIVE);

  ////////////////////////////////////////////////////////////////////////////
  // Event vector and write decode

  aerue_word_t events;
  aerue_word_t be_bits;
  aerue_word_t unmasked_ev;
  logic        wr_status;
  logic        wr_mask;

  always_comb begin
    events = 32'h00000000;
    events[`AERUE_BIT_UR]   = unsupported_request_flag;
    events[`AERUE_BIT_ECRC] = end_to_end_crc_flag;
    events[`AERUE_BIT_MAL]  = malformed_packet_flag;
    events[`AERUE_BIT_OVF]  = receiver_overflow_flag;
    events[`AERUE_BIT_UNXP] = unmatched_completion_flag;
    events[`AERUE_BIT_CA]   = completer_abort_flag;
    events[`AERUE_BIT_CTO]  = completion_timeout_flag;
    events[`AERUE_BIT_FC]   = flow_control_protocol_flag;
    events[`AERUE_BIT_PSN]  = poisoned_packet_flag;
    events[`AERUE_BIT_DLL]  = data_link_protocol_flag;
    // Detectors without support never reach the status word
    events[21] = 1'b0;
    events[5]  = 1'b0;
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      be_bits[i*8 +: 8] = {8{cfg_be[i]}};
    end
  end

  assign wr_status   = cfg_wr && (cfg_addr[11:2] == `AERUE_IDX_STATUS);
  assign wr_mask     = cfg_wr && (cfg_addr[11:2] == `AERUE_IDX_MASK);
  // Held in reset, no event is recorded or reported
  assign unmasked_ev = ext_rst_active ? 32'h00000000
                     : (events & ~uncor_mask & `AERUE_IMPL_BITS);

  ////////////////////////////////////////////////////////////////////////////
  // Status register

  aerue_word_t next_status;
  aerue_word_t clr_bits;

  assign clr_bits = wr_status ? (cfg_wdata & be_bits) : 32'h00000000;
  // Set after clear so a coincident event wins
  assign next_status = ((uncor_status & ~clr_bits) | unmasked_ev)
                     & `AERUE_IMPL_BITS;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uncor_status <= `AERUE_STATUS_RST;
    end else if (ext_rst_active) begin
      uncor_status <= `AERUE_STATUS_RST;
    end else begin
      uncor_status <= next_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mask register

  aerue_word_t next_mask;

  assign next_mask = wr_mask
                   ? ((uncor_mask & ~be_bits) | (cfg_wdata & be_bits)) & `AERUE_IMPL_BITS
                   : uncor_mask;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uncor_mask <= `AERUE_MASK_RST;
    end else if (ext_rst_active) begin
      uncor_mask <= `AERUE_MASK_RST;
    end else begin
      uncor_mask <= next_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Message, header log and first-error pointer requests

  aerue_bitidx_t next_first_idx;

  // Lowest set bit taken as first error when several arrive together
  always_comb begin
    next_first_idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (unmasked_ev[i]) begin
        next_first_idx = i[4:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_msg_req     <= 32'h00000000;
      hdr_log_load    <= 1'b0;
      first_err_load  <= 1'b0;
      first_err_index <= 5'h00;
    end else begin
      err_msg_req    <= unmasked_ev;
      hdr_log_load   <= |unmasked_ev;
      first_err_load <= |unmasked_ev;
      if (|unmasked_ev) begin
        first_err_index <= next_first_idx;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: one cycle latency, unmapped dwords read zero

  aerue_word_t next_rdata;

  always_comb begin
    next_rdata = 32'h00000000;
    unique case (cfg_addr[11:2])
      `AERUE_IDX_CAP:    next_rdata = {`AERUE_NEXT_PTR, `AERUE_CAP_VERSION, 16'h0000};
      `AERUE_IDX_STATUS: next_rdata = uncor_status;
      `AERUE_IDX_MASK:   next_rdata = uncor_mask;
      default:           next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata    <= 32'h00000000;
      cfg_rd_valid <= 1'b0;
    end else begin
      cfg_rd_valid <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_ext_rst_held;
    !link_reset_n [*4];
  endsequence

  sequence s_status_cleared;
    ##[0:4] (uncor_status == 32'h00000000);
  endsequence

  chk_cap_word: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_rd && (cfg_addr[11:2] == `AERUE_IDX_CAP) |=> cfg_rd_valid && (cfg_rdata[31:20] == 12'h000))
    else $error("capability next pointer not zero");

  chk_cap_version: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_rd && (cfg_addr[11:2] == `AERUE_IDX_CAP) |=> (cfg_rdata[19:16] == 4'h1))
    else $error("capability version not one");

  chk_w1c_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_status && cfg_be[2] && cfg_wdata[20] && !unsupported_request_flag
    |=> !uncor_status[20])
    else $error("status bit not cleared by write of one");

  chk_event_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ext_rst_active && end_to_end_crc_flag && !uncor_mask[19] |=> uncor_status[19])
    else $error("unmasked crc event did not set status");

  chk_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ext_rst_active && poisoned_packet_flag && !uncor_mask[12] && wr_status
    && cfg_wdata[12] && cfg_be[1] |=> uncor_status[12])
    else $error("clear beat a coincident event");

  chk_zero_keeps: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ext_rst_active && wr_status && (cfg_wdata == 32'h00000000) |=> uncor_status
    == ($past(uncor_status) | ($past(unmasked_ev))))
    else $error("write of zero changed status");

  chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((uncor_status & ~`AERUE_IMPL_BITS) == 32'h00000000)
    && ((uncor_mask & ~`AERUE_IMPL_BITS) == 32'h00000000))
    else $error("reserved or unsupported bit set");

  chk_mask_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    uncor_mask[18] && !uncor_status[18] |=> !uncor_status[18] && !err_msg_req[18])
    else $error("masked error was recorded or reported");

  chk_mask_no_log: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((events & ~uncor_mask & `AERUE_IMPL_BITS) == 32'h00000000) |=> !hdr_log_load && !first_err_load)
    else $error("header log loaded for masked error");

  chk_ext_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ext_rst_held |-> s_status_cleared)
    else $error("link reset did not clear status");

  chk_mask_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ext_rst_active && wr_mask && (cfg_be == 4'hf)
    |=> uncor_mask == ($past(cfg_wdata) & `AERUE_IMPL_BITS))
    else $error("mask write not stored");

  chk_urq_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ext_rst_active && unsupported_request_flag && !uncor_mask[20]
    |=> uncor_status[20] && err_msg_req[20])
    else $error("unsupported request did not set status");

  chk_malformed_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ext_rst_active && malformed_packet_flag && !uncor_mask[18]
    |=> uncor_status[18] && err_msg_req[18])
    else $error("malformed packet did not set status");

  chk_overflow_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ext_rst_active && receiver_overflow_flag && !uncor_mask[17]
    |=> uncor_status[17] && err_msg_req[17])
    else $error("credit overflow did not set status");

  chk_unmatched_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ext_rst_active && unmatched_completion_flag && !uncor_mask[16]
    |=> uncor_status[16] && err_msg_req[16])
    else $error("unmatched completion did not set status");

  chk_abort_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ext_rst_active && completer_abort_flag && !uncor_mask[15]
    |=> uncor_status[15] && err_msg_req[15])
    else $error("completer abort did not set status");

  chk_timeout_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ext_rst_active && completion_timeout_flag && !uncor_mask[14]
    |=> uncor_status[14] && err_msg_req[14])
    else $error("completion timeout did not set status");

  chk_flowctl_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ext_rst_active && flow_control_protocol_flag && !uncor_mask[13]
    |=> uncor_status[13] && err_msg_req[13])
    else $error("flow control error did not set status");

  chk_poison_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ext_rst_active && poisoned_packet_flag && !uncor_mask[12]
    |=> uncor_status[12] && err_msg_req[12])
    else $error("poisoned packet did not set status");

  chk_dll_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ext_rst_active && data_link_protocol_flag && !uncor_mask[4]
    |=> uncor_status[4] && err_msg_req[4])
    else $error("data link error did not set status");

  chk_unsupported_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    access_control_violation_flag || surprise_link_down_flag
    |=> !uncor_status[21] && !uncor_status[5] && !err_msg_req[21] && !err_msg_req[5])
    else $error("unsupported detector left a trace");

  chk_status_keeps: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ext_rst_active && !wr_status
    |=> ((uncor_status & $past(uncor_status)) == $past(uncor_status)))
    else $error("status bit lost without a clearing write");

  chk_first_error: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (unmasked_ev != 32'h00000000)
    |=> hdr_log_load && first_err_load && (err_msg_req == $past(unmasked_ev)))
    else $error("unmasked error not logged or reported");

  sequence s_glob_rst_held;
    !global_reset_n [*4];
  endsequence

  chk_glob_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_glob_rst_held |-> s_status_cleared)
    else $error("global reset did not clear status");

  sequence s_mask_cleared;
    ##[0:4] (uncor_mask == 32'h00000000);
  endsequence

  chk_mask_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ext_rst_held |-> s_mask_cleared)
    else $error("link reset did not clear mask");

endmodule

// *** tb/aerue_link_model.sv ***
// Link-side model: turns a bench event vector into error detection pulses
`timescale 1ns/100ps
`include "aerue_defs.svh"

module aerue_link_model (
  // Event request, one bit per status position
  input  wire logic [31:0] ev_vec,
  // Detection flags towards the register bank
  output logic             unsupported_request_flag,
  output logic             end_to_end_crc_flag,
  output logic             malformed_packet_flag,
  output logic             receiver_overflow_flag,
  output logic             unmatched_completion_flag,
  output logic             completer_abort_flag,
  output logic             completion_timeout_flag,
  output logic             flow_control_protocol_flag,
  output logic             poisoned_packet_flag,
  output logic             data_link_protocol_flag,
  output logic             access_control_violation_flag,
  output logic             surprise_link_down_flag
);
  // Pulse length is set by how long the bench holds the vector
  assign unsupported_request_flag      = ev_vec[`AERUE_BIT_UR];
  assign end_to_end_crc_flag           = ev_vec[`AERUE_BIT_ECRC];
  assign malformed_packet_flag         = ev_vec[`AERUE_BIT_MAL];
  assign receiver_overflow_flag        = ev_vec[`AERUE_BIT_OVF];
  assign unmatched_completion_flag     = ev_vec[`AERUE_BIT_UNXP];
  assign completer_abort_flag          = ev_vec[`AERUE_BIT_CA];
  assign completion_timeout_flag       = ev_vec[`AERUE_BIT_CTO];
  assign flow_control_protocol_flag    = ev_vec[`AERUE_BIT_FC];
  assign poisoned_packet_flag          = ev_vec[`AERUE_BIT_PSN];
  assign data_link_protocol_flag       = ev_vec[`AERUE_BIT_DLL];
  assign access_control_violation_flag = ev_vec[21];
  assign surprise_link_down_flag       = ev_vec[5];
endmodule

// *** tb/aerue_regs_tb_top.sv ***
// Self-checking bench for the uncorrectable error register bank
`timescale 1ns/100ps
`include "aerue_defs.svh"

module aerue_regs_tb_top;
  import aerue_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, link_reset_n = 1'b1, global_reset_n = 1'b1;
  logic cfg_wr = 1'b0, cfg_rd = 1'b0, cfg_rd_valid, hdr_log_load, first_err_load;
  logic [11:0] cfg_addr = 12'h000;
  logic [3:0]  cfg_be = 4'hf;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, ev_vec = 32'h0, err_msg_req;
  logic [31:0] uncor_status, uncor_mask;
  logic [4:0]  first_err_index;
  wire  [0:0]  f [12];
  int failures = 0, num_checks = 0, cycles = 0;
  int bits [10] = '{20, 19, 18, 17, 16, 15, 14, 13, 12, 4};

  always #12.5 sys_clk = ~sys_clk;

  aerue_link_model i_link (.ev_vec(ev_vec),
    .unsupported_request_flag(f[0][0]), .end_to_end_crc_flag(f[1][0]),
    .malformed_packet_flag(f[2][0]), .receiver_overflow_flag(f[3][0]),
    .unmatched_completion_flag(f[4][0]), .completer_abort_flag(f[5][0]),
    .completion_timeout_flag(f[6][0]), .flow_control_protocol_flag(f[7][0]),
    .poisoned_packet_flag(f[8][0]), .data_link_protocol_flag(f[9][0]),
    .access_control_violation_flag(f[10][0]), .surprise_link_down_flag(f[11][0]));

  aerue_regs i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .link_reset_n(link_reset_n),
    .global_reset_n(global_reset_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rd_valid(cfg_rd_valid), .unsupported_request_flag(f[0][0]),
    .end_to_end_crc_flag(f[1][0]), .malformed_packet_flag(f[2][0]),
    .receiver_overflow_flag(f[3][0]), .unmatched_completion_flag(f[4][0]),
    .completer_abort_flag(f[5][0]), .completion_timeout_flag(f[6][0]),
    .flow_control_protocol_flag(f[7][0]), .poisoned_packet_flag(f[8][0]),
    .data_link_protocol_flag(f[9][0]), .access_control_violation_flag(f[10][0]),
    .surprise_link_down_flag(f[11][0]), .err_msg_req(err_msg_req),
    .hdr_log_load(hdr_log_load), .first_err_load(first_err_load),
    .first_err_index(first_err_index), .uncor_status(uncor_status),
    .uncor_mask(uncor_mask));

  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    step();
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    cfg_be = be;
    step();
    cfg_wr = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    int n;
    step();
    cfg_rd = 1'b1;
    cfg_addr = a;
    step();
    cfg_rd = 1'b0;
    for (n = 0; n < 4 && cfg_rd_valid !== 1'b1; n++) step();
    check({31'h0, cfg_rd_valid}, 32'h1);
    check(cfg_rdata, exp);
  endtask

  // Holds the events for exactly one sampling edge
  task automatic fire(input logic [31:0] ev);
    step();
    ev_vec = ev;
    step();
    ev_vec = 32'h0;
  endtask

  task automatic give_verdict();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Whole run needs well under 2000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (4) step();
    rd(`AERUE_OFS_STATUS, `AERUE_STATUS_RST);
    rd(`AERUE_OFS_MASK, `AERUE_MASK_RST);
    rd(12'h100, {`AERUE_NEXT_PTR, `AERUE_CAP_VERSION, 16'h0});
    wr(12'h100, 32'hffffffff, 4'hf);
    rd(12'h100, 32'h00010000);
    rd(12'h10c, 32'h0);
    foreach (bits[i]) begin
      fire(32'h1 << bits[i]);
      check(uncor_status, 32'h1 << bits[i]);
      check(err_msg_req, 32'h1 << bits[i]);
      check({25'h0, hdr_log_load, first_err_load, first_err_index},
            {25'h0, 2'b11, 5'(bits[i])});
      step();
      check(err_msg_req, 32'h0);
      check({31'h0, hdr_log_load}, 32'h0);
      rd(`AERUE_OFS_STATUS, 32'h1 << bits[i]);
      wr(`AERUE_OFS_STATUS, ~(32'h1 << bits[i]), 4'hf);
      check(uncor_status, 32'h1 << bits[i]);
      wr(`AERUE_OFS_STATUS, 32'h1 << bits[i], 4'hf);
      check(uncor_status, 32'h0);
    end
    fire(32'hffffffff);
    check(uncor_status, `AERUE_IMPL_BITS);
    check(32'(first_err_index), 32'd4);
    // Byte lane 2 disabled: bits 23:16 survive the clearing write
    wr(`AERUE_OFS_STATUS, 32'hffffffff, 4'hb);
    check(uncor_status, 32'h001f0000);
    // Clear and a new event in the same cycle: the event wins
    step();
    cfg_wr = 1'b1;
    cfg_be = 4'hf;
    cfg_addr = `AERUE_OFS_STATUS;
    cfg_wdata = 32'hffffffff;
    ev_vec = 32'h1 << `AERUE_BIT_PSN;
    step();
    cfg_wr = 1'b0;
    ev_vec = 32'h0;
    check(uncor_status, 32'h1 << `AERUE_BIT_PSN);
    wr(`AERUE_OFS_STATUS, 32'hffffffff, 4'hf);
    wr(`AERUE_OFS_MASK, 32'hffffffff, 4'hf);
    rd(`AERUE_OFS_MASK, `AERUE_IMPL_BITS);
    fire(32'hffffffff);
    check(uncor_status, 32'h0);
    check(err_msg_req, 32'h0);
    check({30'h0, hdr_log_load, first_err_load}, 32'h0);
    check(32'(first_err_index), 32'(`AERUE_BIT_PSN));
    wr(`AERUE_OFS_MASK, 32'h0, 4'h3);
    check(uncor_mask, 32'h001f0000);
    // Each external reset pin in turn clears status and mask
    for (int p = 0; p < 2; p++) begin
      fire(32'h1 << `AERUE_BIT_DLL);
      check(uncor_status, 32'h1 << `AERUE_BIT_DLL);
      step();
      if (p == 0) link_reset_n = 1'b0;
      else global_reset_n = 1'b0;
      repeat (8) step();
      check(uncor_status, 32'h0);
      check(uncor_mask, 32'h0);
      link_reset_n = 1'b1;
      global_reset_n = 1'b1;
      repeat (6) step();
      rd(`AERUE_OFS_STATUS, 32'h0);
      // Nonzero mask so the next reset has something to clear
      wr(`AERUE_OFS_MASK, 32'h1 << `AERUE_BIT_UR, 4'hf);
      check(uncor_mask, 32'h1 << `AERUE_BIT_UR);
    end
    // Power-on reset in mid-run clears status and mask at once
    fire(32'h1 << `AERUE_BIT_CA);
    check(uncor_status, 32'h1 << `AERUE_BIT_CA);
    rst_n = 1'b0;
    step();
    check(uncor_status, 32'h0);
    check(uncor_mask, 32'h0);
    rst_n = 1'b1;
    repeat (4) step();
    rd(`AERUE_OFS_STATUS, 32'h0);
    give_verdict();
  end
endmodule
